// *** verilog/cpu_bus_glue_decode.sv ***
`timescale 1ns/100ps
module cpu_bus_glue_decode #(
    parameter int POR_CYCLES = glue_pkg::POR_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        osc_in,
    input  wire logic        manual_reset_n,
    input  wire logic        kernel_test_n,
    input  wire logic        display_busy,
    input  wire logic        comm_fitted,
    input  wire logic        comm_ready,
    input  wire logic        ale,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        io_m,
    input  wire logic        inta_n,
    input  wire logic        data_path_enable_n,
    input  wire logic        transfer_direction,
    input  wire logic [7:0]  ad_in,
    output logic      [7:0]  ad_out,
    output logic             ad_oe_n,
    input  wire logic [11:0] addr_hi,
    input  wire logic [7:0]  panel_sw0,
    input  wire logic [7:0]  panel_sw1,
    input  wire logic [7:0]  sys_data_in,
    output logic      [7:0]  sys_data_out,
    output logic             sys_data_oe_n,
    output logic             cpu_clk,
    output logic             disp_clk,
    output logic             ctl_bus_clk,
    output logic             pclk,
    output logic             slow_tick,
    output logic             cpu_reset,
    output logic             disp_reset,
    output logic             cpu_ready,
    output logic      [19:0] latched_addr,
    output logic      [3:0]  bus_status,
    output logic      [3:0]  block_n,
    output logic      [3:0]  seg_n,
    output logic             ram_sel_n,
    output logic             peripheral_segment_hit_n,
    output logic      [3:0]  io_lo_n,
    output logic      [3:0]  io_hi_n,
    output logic      [1:0]  rom_cs_n,
    output logic      [15:0] rom_addr
);
    clk_if ck ();

    logic [glue_pkg::SYNC_W-1:0] meta_q;
    logic [glue_pkg::SYNC_W-1:0] sync_q;
    logic [glue_pkg::SYNC_W-1:0] raw;
    logic [glue_pkg::SYNC_W-1:0] sync_rst;
    logic        ale_s;
    logic        rd_s;
    logic        wr_s;
    logic        io_m_s;
    logic        inta_s;
    logic        dpe_s;
    logic        dir_s;
    logic        busy_s;
    logic        fitted_s;
    logic        comm_ready_s;
    logic        ktest_s;
    logic [7:0]  ad_s;
    logic [11:0] hi_s;
    logic [7:0]  sw0_s;
    logic [7:0]  sw1_s;
    logic [7:0]  sysd_s;
    logic        ale_d_q;
    logic [19:0] addr_q;
    logic [3:0]  status_q;
    logic        strobe;
    logic        lo_en;
    logic        up_en;
    logic        panel0_on;
    logic        panel1_on;
    logic        inta_cycle;
    logic        xcvr_on;
    logic        data_phase;
    logic [7:0]  pull_val;

    // every pin passes two flops; rd, wr, inta and data enable strobes, comm ready and kernel test reset high, the rest low
    assign raw = {ale, rd_n, wr_n, io_m, inta_n, data_path_enable_n, transfer_direction,
                  display_busy, comm_fitted, comm_ready, kernel_test_n,
                  ad_in, addr_hi, panel_sw0, panel_sw1, sys_data_in};
    assign sync_rst = {1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
                       1'b0, 1'b0, 1'b1, 1'b1, 44'h0};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= sync_rst;
            sync_q <= sync_rst;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end

    assign {ale_s, rd_s, wr_s, io_m_s, inta_s, dpe_s, dir_s,
            busy_s, fitted_s, comm_ready_s, ktest_s,
            ad_s, hi_s, sw0_s, sw1_s, sysd_s} = sync_q;

    clock_gen #(
        .POR_CYCLES (POR_CYCLES)
    ) u_clock_gen (
        .clk            (clk),
        .rst_n          (rst_n),
        .osc_in         (osc_in),
        .manual_reset_n (manual_reset_n),
        .ck             (ck)
    );

    assign cpu_clk     = ck.cpu_clk;
    assign disp_clk    = ck.cpu_clk;
    assign ctl_bus_clk = ck.cpu_clk;
    assign pclk        = ck.pclk;
    assign slow_tick   = ck.slow_tick;
    assign cpu_reset   = ck.cpu_reset;
    assign disp_reset  = ck.disp_reset;
    assign cpu_ready   = ck.cpu_ready;

    // address is transparent while the strobe is high, held after
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ale_d_q <= 1'b0;
            addr_q  <= 20'h00000;
        end else begin
            ale_d_q <= ale_s;
            if (ale_s) begin
                addr_q <= {hi_s, ad_s};
            end
        end
    end

    // a19..a16 turn into status once the strobe falls
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_q <= 4'h0;
        end else if (ale_d_q && !ale_s) begin
            status_q <= hi_s[11:8];
        end
    end

    assign latched_addr = addr_q;
    assign bus_status   = status_q;

    dec_1of4 u_blk_dec (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (1'b1),
        .sel   (addr_q[glue_pkg::A_BLK_LO +: 2]),
        .y_n   (block_n)
    );

    dec_1of4 u_seg_dec (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (1'b1),
        .sel   (addr_q[glue_pkg::A_SEG_LO +: 2]),
        .y_n   (seg_n)
    );

    assign ram_sel_n                = seg_n[glue_pkg::SEG_RAM];
    assign peripheral_segment_hit_n = seg_n[glue_pkg::SEG_IO];

    // block outputs come a cycle after the address, so the i/o
    // decode trails the block decode by one more cycle
    assign strobe = !rd_s || !wr_s;
    assign lo_en  = strobe && !block_n[glue_pkg::BLK_ZERO] && !peripheral_segment_hit_n;
    assign up_en  = lo_en && addr_q[glue_pkg::A_IO_HI] && addr_q[glue_pkg::A_IO_LO];

    dec_1of4 u_io_lo_dec (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (lo_en),
        .sel   ({addr_q[glue_pkg::A_IO_SEL_LO], addr_q[0]}),
        .y_n   (io_lo_n)
    );

    dec_1of4 u_io_hi_dec (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (up_en),
        .sel   ({addr_q[glue_pkg::A_IO_SEL_HI], addr_q[0]}),
        .y_n   (io_hi_n)
    );

    // rom pick on a15, a16 chooses the half inside each rom
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rom_cs_n <= 2'h3;
            rom_addr <= 16'h0000;
        end else begin
            rom_cs_n[0] <= (addr_q[glue_pkg::A_SEG_LO +: 2] != glue_pkg::SEG_ROM)
                           || addr_q[glue_pkg::A_ROM_PICK];
            rom_cs_n[1] <= (addr_q[glue_pkg::A_SEG_LO +: 2] != glue_pkg::SEG_ROM)
                           || !addr_q[glue_pkg::A_ROM_PICK];
            rom_addr    <= {addr_q[glue_pkg::A_ROM_HALF], addr_q[14:0]};
        end
    end

    // display first on ram; a comm option stalls its own segment
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ck.wait_request <= 1'b0;
        end else begin
            ck.wait_request <= (strobe && !ram_sel_n && busy_s)
                            || (strobe && fitted_s && !comm_ready_s && !seg_n[glue_pkg::SEG_COMM]);
        end
    end

    assign panel0_on  = !addr_q[glue_pkg::A_PANEL] && !io_hi_n[0];
    assign panel1_on  = !addr_q[glue_pkg::A_PANEL] && !io_hi_n[1];
    assign inta_cycle = !inta_s && io_m_s;
    assign xcvr_on    = !dpe_s && !inta_cycle;
    assign data_phase = !ale_s;
    assign pull_val   = ktest_s ? glue_pkg::IRQ_VECTOR : glue_pkg::NOP_CODE;

    // processor side: one driver at a time, panel first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ad_out  <= 8'h00;
            ad_oe_n <= 1'b1;
        end else if (panel0_on) begin
            ad_out  <= sw0_s;
            ad_oe_n <= 1'b0;
        end else if (panel1_on) begin
            ad_out  <= sw1_s;
            ad_oe_n <= 1'b0;
        end else if (xcvr_on && !dir_s && data_phase) begin
            ad_out  <= sysd_s;
            ad_oe_n <= 1'b0;
        end else begin
            // undriven bus reads the pull-up pattern
            ad_out  <= pull_val;
            ad_oe_n <= 1'b1;
        end
    end

    // device side: address slot never reaches the peripherals
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sys_data_out  <= 8'h00;
            sys_data_oe_n <= 1'b1;
        end else begin
            if (xcvr_on && dir_s && data_phase) begin
                sys_data_out <= ad_s;
            end
            sys_data_oe_n <= !(xcvr_on && dir_s && data_phase);
        end
    end

    a_addr_capture: assert property (@(posedge clk) disable iff (!rst_n)
        ale_s
        |=> addr_q == $past({hi_s, ad_s}))
        else $error("address not captured on strobe");

    a_addr_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !ale_s
        |=> $stable(addr_q))
        else $error("address changed without strobe");

    a_status_split: assert property (@(posedge clk) disable iff (!rst_n)
        ale_d_q && !ale_s
        |=> status_q == $past(hi_s[11:8]))
        else $error("status not separated from address");

    a_seg_decode: assert property (@(posedge clk) disable iff (!rst_n)
        addr_q[19:18] == glue_pkg::SEG_IO
        |=> !peripheral_segment_hit_n && seg_n[0] && seg_n[2] && seg_n[3])
        else $error("peripheral segment not decoded");

    a_block_decode: assert property (@(posedge clk) disable iff (!rst_n)
        addr_q[15:14] == glue_pkg::BLK_ZERO
        |=> block_n == 4'he)
        else $error("block zero not decoded");

    a_block_gate: assert property (@(posedge clk) disable iff (!rst_n)
        block_n[glue_pkg::BLK_ZERO]
        |=> io_lo_n == 4'hf && io_hi_n == 4'hf)
        else $error("i/o decoder active outside block zero");

    a_io_lo_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !lo_en
        |=> io_lo_n == 4'hf)
        else $error("lower i/o decoder active while disabled");

    a_io_hi_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !(addr_q[13] && addr_q[12])
        |=> io_hi_n == 4'hf)
        else $error("upper i/o decoder active without a13 and a12");

    a_one_low: assert property (@(posedge clk) disable iff (!rst_n)
        lo_en
        |=> $onehot(~io_lo_n))
        else $error("enabled decoder lacks a single low output");

    a_panel_drive: assert property (@(posedge clk) disable iff (!rst_n)
        panel0_on
        |=> !ad_oe_n && ad_out == $past(sw0_s))
        else $error("panel buffer not driven");

    a_panel_second: assert property (@(posedge clk) disable iff (!rst_n)
        panel1_on && !panel0_on
        |=> !ad_oe_n && ad_out == $past(sw1_s))
        else $error("second panel buffer not driven");

    a_xcvr_receive: assert property (@(posedge clk) disable iff (!rst_n)
        !panel0_on && !panel1_on && xcvr_on && !dir_s && data_phase
        |=> !ad_oe_n && ad_out == $past(sysd_s))
        else $error("device data not passed to processor");

    a_xcvr_send: assert property (@(posedge clk) disable iff (!rst_n)
        xcvr_on && dir_s && data_phase
        |=> !sys_data_oe_n && sys_data_out == $past(ad_s))
        else $error("processor data not passed to device");

    a_addr_slot: assert property (@(posedge clk) disable iff (!rst_n)
        ale_s
        |=> $stable(sys_data_out) && sys_data_oe_n)
        else $error("address slot passed to device side");

    a_inta_gate: assert property (@(posedge clk) disable iff (!rst_n)
        inta_cycle
        |=> sys_data_oe_n)
        else $error("transceiver open during interrupt acknowledge");

    a_pullup_val: assert property (@(posedge clk) disable iff (!rst_n)
        !panel0_on && !panel1_on && !xcvr_on && ktest_s
        |=> ad_oe_n && ad_out == glue_pkg::IRQ_VECTOR)
        else $error("pull-up pattern wrong");

    a_nop_fill: assert property (@(posedge clk) disable iff (!rst_n)
        !panel0_on && !panel1_on && !xcvr_on && !ktest_s
        |=> ad_oe_n && ad_out == glue_pkg::NOP_CODE)
        else $error("kernel test pattern wrong");

    a_ram_wait: assert property (@(posedge clk) disable iff (!rst_n)
        strobe && !ram_sel_n && busy_s
        |=> ck.wait_request)
        else $error("no wait while display owns ram");

    a_comm_wait: assert property (@(posedge clk) disable iff (!rst_n)
        strobe && fitted_s && !comm_ready_s && !seg_n[glue_pkg::SEG_COMM]
        |=> ck.wait_request)
        else $error("no wait while comm option busy");
endmodule

// *** pkg/glue_pkg.sv ***
// Operation
// - processor clock is oscillator divided by three
// - peripheral clock is half processor clock rate
// - processor clock also feeds display and control bus
// - power-on delay holds processor reset; manual reset holds both resets
// - display wins ram; wait stalls the processor
// - fitted comm option also stalls the processor
// - pull-ups give vector pointer, or no-op in test
// - latch address on strobe, hold until next
// - separate multiplexed status from upper address lines
// - block decoder: a15:a14; segment decoder: latched a19:a18
// - i/o decoders enabled only inside block zero
// - lower i/o: strobe, block zero, segment hit
// - upper i/o only when a13 and a12 high
// - interrupt vectors 00008 and 03fc lie in ram
// - panel buffer drives when a2 and select low
// - transceiver passes on data enable; direction selects
// - i/o qualifier gates transceiver during interrupt acknowledge
// - device side uses data phase only
// - program store is two 64k by 8 roms
// - peripheral segment 40000-7ffff, four images
package glue_pkg;
    localparam int CLK_MHZ      = 50;
    localparam int OSC_DIV      = 3;
    localparam int SLOW_BITS    = 4;
    localparam int POR_TIME_US  = 200;
    localparam int POR_CYCLES   = POR_TIME_US * CLK_MHZ;
    localparam int POR_W        = 16;
    localparam logic [1:0] DIV_LAST = 2'(OSC_DIV - 1);
    localparam logic [1:0] SEG_RAM  = 2'h0;
    localparam logic [1:0] SEG_IO   = 2'h1;
    localparam logic [1:0] SEG_COMM = 2'h2;
    localparam logic [1:0] SEG_ROM  = 2'h3;
    localparam logic [1:0] BLK_ZERO = 2'h0;
    localparam int A_PANEL      = 2;
    localparam int A_IO_LO      = 12;
    localparam int A_IO_HI      = 13;
    localparam int A_BLK_LO     = 14;
    localparam int A_ROM_PICK   = 15;
    localparam int A_ROM_HALF   = 16;
    localparam int A_SEG_LO     = 18;
    localparam int A_IO_SEL_LO  = 11;
    localparam int A_IO_SEL_HI  = 10;
    localparam logic [19:0] NMI_VEC_ADDR  = 20'h00008;
    localparam logic [19:0] IRQ_VEC_ADDR  = 20'h003fc;
    localparam logic [7:0]  IRQ_VECTOR    = IRQ_VEC_ADDR[9:2];
    // arbitrary value: set to the processor's no-op opcode
    localparam logic [7:0]  NOP_CODE      = 8'h00;
    localparam int SYNC_W       = 55;
endpackage

// *** pkg/clk_if.sv ***
`timescale 1ns/100ps
interface clk_if;
    logic cpu_clk;
    logic pclk;
    logic slow_tick;
    logic cpu_reset;
    logic disp_reset;
    logic wait_request;
    logic cpu_ready;
    modport gen  (output cpu_clk, pclk, slow_tick, cpu_reset, disp_reset, cpu_ready, input wait_request);
    modport user (input cpu_clk, pclk, slow_tick, cpu_reset, disp_reset, cpu_ready, output wait_request);
endinterface

// *** verilog/dec_1of4.sv ***
`timescale 1ns/100ps
module dec_1of4 (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       en,
    input  wire logic [1:0] sel,
    output logic      [3:0] y_n
);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            y_n <= 4'hf;
        end else if (en) begin
            y_n <= ~(4'h1 << sel);
        end else begin
            y_n <= 4'hf;
        end
    end
endmodule

// *** verilog/clock_gen.sv ***
`timescale 1ns/100ps
module clock_gen #(
    parameter int POR_CYCLES = glue_pkg::POR_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic osc_in,
    input  wire logic manual_reset_n,
    clk_if.gen        ck
);
    logic [1:0]                  meta_q;
    logic [1:0]                  sync_q;
    logic                        osc_d_q;
    logic [1:0]                  div_q;
    logic [glue_pkg::SLOW_BITS-1:0] slow_q;
    logic                        pclk_d_q;
    logic [glue_pkg::POR_W-1:0]  por_q;
    logic                        osc_edge;
    logic                        cpu_rise;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= 2'h2;
            sync_q <= 2'h2;
        end else begin
            meta_q <= {manual_reset_n, osc_in};
            sync_q <= meta_q;
        end
    end

    assign osc_edge = sync_q[0] && !osc_d_q;
    assign cpu_rise = osc_edge && (div_q == glue_pkg::DIV_LAST);

    // cpu clock high one oscillator period in three
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            osc_d_q    <= 1'b0;
            div_q      <= 2'h0;
            ck.cpu_clk <= 1'b0;
            ck.pclk    <= 1'b0;
        end else begin
            osc_d_q <= sync_q[0];
            if (osc_edge) begin
                div_q      <= cpu_rise ? 2'h0 : div_q + 2'h1;
                ck.cpu_clk <= cpu_rise;
            end
            if (cpu_rise) begin
                ck.pclk <= !ck.pclk;
            end
        end
    end

    // ripple counter stand-in: counts peripheral clock rises
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pclk_d_q     <= 1'b0;
            slow_q       <= '0;
            ck.slow_tick <= 1'b0;
        end else begin
            pclk_d_q <= ck.pclk;
            if (ck.pclk && !pclk_d_q) begin
                slow_q <= slow_q + 1'b1;
            end
            ck.slow_tick <= slow_q[glue_pkg::SLOW_BITS-1];
        end
    end

    // manual request reloads the delay so release is clean
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            por_q         <= glue_pkg::POR_W'(POR_CYCLES);
            ck.cpu_reset  <= 1'b1;
            ck.disp_reset <= 1'b1;
        end else begin
            if (!sync_q[1]) begin
                por_q <= glue_pkg::POR_W'(POR_CYCLES);
            end else if (por_q != '0) begin
                por_q <= por_q - 1'b1;
            end
            ck.cpu_reset  <= !sync_q[1] || (por_q != '0);
            ck.disp_reset <= !sync_q[1];
        end
    end

    // ready sampled only at cpu clock rises, as the processor expects
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ck.cpu_ready <= 1'b1;
        end else if (cpu_rise) begin
            ck.cpu_ready <= !ck.wait_request;
        end
    end

    a_cpu_div_three: assert property (@(posedge clk) disable iff (!rst_n)
        osc_edge && div_q != glue_pkg::DIV_LAST |=> !ck.cpu_clk)
        else $error("cpu clock high off the third oscillator edge");
    a_pclk_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_rise |=> ck.pclk != $past(ck.pclk))
        else $error("peripheral clock did not toggle on cpu clock rise");
    a_manual_reset: assert property (@(posedge clk) disable iff (!rst_n)
        !sync_q[1] |=> ck.cpu_reset && ck.disp_reset)
        else $error("manual reset did not reset both parties");
    a_ready_stall: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_rise && ck.wait_request |=> !ck.cpu_ready)
        else $error("processor not stalled by wait request");
endmodule

// *** sim/cpu_model.sv ***
`timescale 1ns/100ps
module cpu_model (
    input  wire logic        clk,
    input  wire logic        cpu_ready,
    input  wire logic [7:0]  ad_bus,
    output logic             ale,
    output logic             rd_n,
    output logic             wr_n,
    output logic             io_m,
    output logic             inta_n,
    output logic             dpe_n,
    output logic             dir,
    output logic [7:0]       ad_drv,
    output logic             ad_drv_en,
    output logic [11:0]      addr_hi
);
    initial begin
        {ale, io_m, dir, ad_drv_en} = 4'h0;
        {rd_n, wr_n, inta_n, dpe_n} = 4'hf;
        ad_drv = 8'h00;
        addr_hi = 12'h000;
    end
    // kind 0 read, 1 write, 2 interrupt acknowledge; status stays on the upper lines
    task automatic bus_cycle(input logic [19:0] a, input int kind, input logic [7:0] wd,
                             output logic [7:0] rd, output bit ok);
        int n;
        // turnaround: a read's drivers need a few cycles to clear the bus
        repeat (5) @(negedge clk);
        ale = 1'b1;
        addr_hi = a[19:8];
        ad_drv = a[7:0];
        ad_drv_en = 1'b1;
        io_m = (kind == 2);
        repeat (4) @(negedge clk);
        ale = 1'b0;
        ad_drv = wd;
        ad_drv_en = (kind == 1);
        dir = (kind == 1);
        dpe_n = 1'b0;
        rd_n = (kind != 0);
        wr_n = (kind != 1);
        inta_n = (kind != 2);
        repeat (16) @(negedge clk);
        // a stalled processor holds its strobe until ready returns
        for (n = 0; n < 200 && cpu_ready !== 1'b1; n++) @(negedge clk);
        ok = (n < 200);
        rd = ad_bus;
        {rd_n, wr_n, inta_n, dpe_n} = 4'hf;
        {io_m, ad_drv_en} = 2'h0;
        ad_drv = ~wd;
    endtask
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`define check_eq(nm, ex, gt) begin \
    n_compared++; \
    if ((gt) !== (ex)) begin \
        err_total++; \
        $display("FAIL %s expected %h seen %h", nm, ex, gt); \
    end \
end
module tb_top;
    logic clk, rst_n, osc_in, manual_reset_n, kernel_test_n, display_busy, comm_fitted, comm_ready;
    logic ale, rd_n, wr_n, io_m, inta_n, dpe_n, dir, ad_drv_en, ad_oe_n, sys_data_oe_n;
    logic cpu_clk, disp_clk, ctl_bus_clk, pclk, slow_tick, cpu_reset, disp_reset, cpu_ready;
    logic ram_sel_n, peripheral_segment_hit_n, cpu_q, p_q, s_q;
    logic [7:0] ad_drv, ad_out, panel_sw0, panel_sw1, sys_data_in, sys_data_out, rd;
    logic [11:0] addr_hi;
    logic [19:0] latched_addr, a;
    logic [3:0] bus_status, block_n, seg_n, io_lo_n, io_hi_n;
    logic [1:0] rom_cs_n;
    logic [15:0] rom_addr;
    logic [31:0] seed = 32'h00015731;
    logic [31:0] r;
    wire [7:0] ad_bus = (!ad_oe_n && ad_drv_en) ? 8'hxx : (ad_drv_en ? ad_drv : ad_out);
    int err_total = 0, n_compared = 0, n, c_cpu, c_p, c_s, c_diff, kind;
    bit ok;
    logic [19:0] corner [8] = '{20'h433f0, 20'h433f1, 20'h433f4, 20'h00000,
                                20'h7ffff, 20'h40000, 20'hfffff, 20'h80000};

    cpu_bus_glue_decode #(.POR_CYCLES(20)) u_dut (
        .clk(clk), .rst_n(rst_n), .osc_in(osc_in), .manual_reset_n(manual_reset_n),
        .kernel_test_n(kernel_test_n), .display_busy(display_busy), .comm_fitted(comm_fitted),
        .comm_ready(comm_ready), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .io_m(io_m), .inta_n(inta_n),
        .data_path_enable_n(dpe_n), .transfer_direction(dir), .ad_in(ad_bus), .ad_out(ad_out),
        .ad_oe_n(ad_oe_n), .addr_hi(addr_hi), .panel_sw0(panel_sw0), .panel_sw1(panel_sw1),
        .sys_data_in(sys_data_in), .sys_data_out(sys_data_out), .sys_data_oe_n(sys_data_oe_n),
        .cpu_clk(cpu_clk), .disp_clk(disp_clk), .ctl_bus_clk(ctl_bus_clk), .pclk(pclk),
        .slow_tick(slow_tick), .cpu_reset(cpu_reset), .disp_reset(disp_reset), .cpu_ready(cpu_ready),
        .latched_addr(latched_addr), .bus_status(bus_status), .block_n(block_n), .seg_n(seg_n),
        .ram_sel_n(ram_sel_n), .peripheral_segment_hit_n(peripheral_segment_hit_n),
        .io_lo_n(io_lo_n), .io_hi_n(io_hi_n), .rom_cs_n(rom_cs_n), .rom_addr(rom_addr));

    cpu_model u_cpu (
        .clk(clk), .cpu_ready(cpu_ready), .ad_bus(ad_bus), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .io_m(io_m), .inta_n(inta_n), .dpe_n(dpe_n), .dir(dir), .ad_drv(ad_drv),
        .ad_drv_en(ad_drv_en), .addr_hi(addr_hi));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // offset so oscillator edges never meet a clock edge
    initial begin
        osc_in = 1'b0;
        #2;
        forever #25 osc_in = ~osc_in;
    end
    always @(negedge clk) begin
        c_cpu += (cpu_clk && !cpu_q);
        c_p += (pclk && !p_q);
        c_s += (slow_tick && !s_q);
        c_diff += (disp_clk !== cpu_clk) || (ctl_bus_clk !== cpu_clk);
        {cpu_q, p_q, s_q} = {cpu_clk, pclk, slow_tick};
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] exp_read(input logic [19:0] x);
        logic hi;
        hi = x[19:18] == 2'h1 && x[15:12] == 4'h3 && !x[2] && !x[10];
        if (hi && !x[0]) return panel_sw0;
        if (hi && x[0]) return panel_sw1;
        return sys_data_in;
    endfunction
    task automatic results();
        if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cyc(input logic [19:0] x, input int k, input logic [7:0] wd);
        u_cpu.bus_cycle(x, k, wd, rd, ok);
        if (!ok) begin
            err_total++;
            results();
        end
    endtask
    task automatic check_addr(input logic [19:0] x);
        logic lo;
        lo = (x[15:14] == 2'h0) && (x[19:18] == 2'h1);
        `check_eq("latched_addr", x, latched_addr)
        `check_eq("bus_status", x[19:16], bus_status)
        `check_eq("block_n", ~(4'h1 << x[15:14]), block_n)
        `check_eq("seg_n", ~(4'h1 << x[19:18]), seg_n)
        `check_eq("seg_hit_n", !(x[19:18] == 2'h1), peripheral_segment_hit_n)
        `check_eq("ram_sel_n", !(x[19:18] == 2'h0), ram_sel_n)
        `check_eq("io_lo_n", (lo ? ~(4'h1 << {x[11], x[0]}) : 4'hf), io_lo_n)
        `check_eq("io_hi_n", ((lo && x[13] && x[12]) ? ~(4'h1 << {x[10], x[0]}) : 4'hf), io_hi_n)
        `check_eq("rom_cs_n", ((x[19:18] == 2'h3) ? ~(2'h1 << x[15]) : 2'h3), rom_cs_n)
        if (x[19:18] == 2'h3) `check_eq("rom_addr", ({x[16], x[14:0]}), rom_addr)
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        results();
    end

    initial begin
        {rst_n, display_busy, comm_fitted} = 3'h0;
        {manual_reset_n, kernel_test_n, comm_ready} = 3'h7;
        {panel_sw0, panel_sw1, sys_data_in} = 24'h0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        for (n = 0; n < 200 && cpu_reset !== 1'b0; n++) @(negedge clk);
        `check_eq("por_len", 1'b1, (n >= 20 && n <= 26))
        `check_eq("disp_reset", 1'b0, disp_reset)
        {c_cpu, c_p, c_s, c_diff} = '0;
        // 2400 cycles hold a whole number of every divided period
        repeat (2400) @(negedge clk);
        `check_eq("cpu_clk_rises", 320, c_cpu)
        `check_eq("pclk_rises", 160, c_p)
        `check_eq("slow_rises", 10, c_s)
        `check_eq("clk_copies", 0, c_diff)
        for (int i = 0; i < 56; i++) begin
            r = xs();
            a = (i < 8) ? corner[i] : r[19:0];
            if (i >= 8 && r[21:20] == 2'h0) a[19:12] = 8'h43;
            kind = (i >= 8 && r[23:22] == 2'h0);
            if (kind == 1) a[2] = 1'b1;
            r = xs();
            {panel_sw0, panel_sw1, sys_data_in} = r[23:0];
            cyc(a, kind, r[31:24]);
            check_addr(a);
            if (kind == 0) `check_eq("rdata", exp_read(a), rd)
            `check_eq("dev_oe_n", (kind == 0), sys_data_oe_n)
            if (kind == 1) `check_eq("dev_data", r[31:24], sys_data_out)
            `check_eq("ready_idle", 1'b1, cpu_ready)
        end
        sys_data_in = 8'h5a;
        for (int k = 0; k < 2; k++) begin
            kernel_test_n = k[0];
            cyc(20'h00000, 2, 8'h00);
            `check_eq("pullup", (k ? glue_pkg::IRQ_VECTOR : glue_pkg::NOP_CODE), rd)
        end
        // display owns ram, then comm option not ready, each released mid-stall
        for (int k = 0; k < 2; k++) begin
            display_busy = (k == 0);
            {comm_fitted, comm_ready} = {k[0], 1'b0};
            fork
                cyc(k ? 20'h80010 : 20'h00100, 0, 8'h00);
                begin
                    repeat (30) @(negedge clk);
                    `check_eq("stall", 1'b0, cpu_ready)
                    {display_busy, comm_ready} = 2'h1;
                end
            join
        end
        display_busy = 1'b1;
        comm_fitted = 1'b0;
        comm_ready = 1'b0;
        cyc(20'h80010, 0, 8'h00);
        cyc(20'hffff0, 0, 8'h00);
        check_addr(20'hffff0);
        `check_eq("no_stall", 1'b1, cpu_ready)
        manual_reset_n = 1'b0;
        repeat (8) @(negedge clk);
        `check_eq("man_cpu", 1'b1, cpu_reset)
        `check_eq("man_disp", 1'b1, disp_reset)
        manual_reset_n = 1'b1;
        repeat (10) @(negedge clk);
        `check_eq("man_disp_rel", 1'b0, disp_reset)
        `check_eq("man_cpu_hold", 1'b1, cpu_reset)
        for (n = 0; n < 200 && cpu_reset !== 1'b0; n++) @(negedge clk);
        `check_eq("man_por", 1'b1, (n < 20))
        results();
    end
endmodule
